// File: hdl/bus_sequencer.sv
module bus_sequencer (
    input wire logic mclk,
    input wire logic rst,
    input wire logic clock_doubled,
    input wire logic req_valid,
    input wire pipe_bus_pkg::bus_req_t req_cycle,
    output logic req_ready,
    output logic rsp_valid,
    output logic rsp_write,
    output logic [pipe_bus_pkg::DATA_W-1:0] rsp_data,
    pipe_bus_if.cpu_end bus
);
    import pipe_bus_pkg::*;

    bus_state_t state_q, state_d;
    logic ph_q;
    logic na_q;
    logic p1_end, na_now, ready, pend, issue, ends, done, push;
    bus_req_t buf_q [BUF_DEPTH];
    logic wr_ptr_q, rd_ptr_q;
    logic [1:0] cnt_q, cnt_d;
    bus_req_t head, cur_q, nxt_q;

    ////////////////////////////////////////////////////////////////////////////
    // Bus state timing from the fast clock

    // Phase one ends on the first fast clock; doubled mode has one clock per state
    assign p1_end = clock_doubled || !ph_q;

    always_ff @(posedge mclk) begin
        if (rst) begin
            ph_q <= 1'b0;
            bus.state_end <= 1'b0;
        end else begin
            ph_q <= clock_doubled ? 1'b0 : !ph_q;
            bus.state_end <= clock_doubled || !ph_q;
        end
    end

    // The request input is taken at the end of every phase one
    always_ff @(posedge mclk) begin
        if (rst) begin
            na_q <= 1'b0;
        end else if (p1_end) begin
            na_q <= bus.next_address_request;
        end
    end

    // In doubled mode phase one ends together with the state
    assign na_now = clock_doubled ? bus.next_address_request : na_q;
    assign ready = !bus.cycle_done_n;

    ////////////////////////////////////////////////////////////////////////////
    // Two-entry request buffer; the head is the internally pending cycle

    assign head = buf_q[rd_ptr_q];
    assign pend = cnt_q != 2'd0;
    assign push = req_valid && req_ready;

    always_comb begin
        cnt_d = cnt_q;
        if (push && !issue) begin
            cnt_d = cnt_q + 2'd1;
        end else if (issue && !push) begin
            cnt_d = cnt_q - 2'd1;
        end
    end

    // Ready is registered, so a full buffer stalls the core one cycle longer at most
    always_ff @(posedge mclk) begin
        if (rst) begin
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
            cnt_q <= 2'd0;
            req_ready <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            req_ready <= cnt_d != 2'd2;
            if (push) begin
                wr_ptr_q <= !wr_ptr_q;
            end
            if (issue) begin
                rd_ptr_q <= !rd_ptr_q;
            end
        end
    end

    // Buffer storage carries no reset
    always_ff @(posedge mclk) begin
        if (push) begin
            buf_q[wr_ptr_q] <= req_cycle;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic, evaluated once per bus state

    always_comb begin
        state_d = state_q;
        issue = 1'b0;
        ends = 1'b0;
        if (bus.state_end) begin
            case (state_q)
                idle_state: begin
                    if (bus.hold_request) begin
                        state_d = hold_state;
                    end else if (pend) begin
                        state_d = first_state;
                        issue = 1'b1;
                    end
                end
                hold_state: begin
                    if (!bus.hold_request) begin
                        state_d = idle_state;
                    end
                end
                first_state: begin
                    state_d = second_state;
                end
                second_state: begin
                    if (ready) begin
                        ends = 1'b1;
                    end else if (na_now && pend) begin
                        state_d = pipe_next_addr_state;
                        issue = 1'b1;
                    end
                end
                pipe_first_state: begin
                    // Acknowledge is not looked at here
                    if (pend && na_now) begin
                        state_d = pipe_next_addr_state;
                        issue = 1'b1;
                    end else if (!pend) begin
                        state_d = pipe_no_request_state;
                    end else begin
                        state_d = second_state;
                    end
                end
                pipe_no_request_state: begin
                    if (ready) begin
                        ends = 1'b1;
                    end else if (pend) begin
                        state_d = pipe_next_addr_state;
                        issue = 1'b1;
                    end
                end
                pipe_next_addr_state: begin
                    // Only one cycle may be issued ahead; repeats wait here
                    if (ready) begin
                        state_d = pipe_first_state;
                    end
                end
                default: begin
                    state_d = idle_state;
                end
            endcase
            // A cycle that ends without an early address falls back to nonpipelined
            if (ends) begin
                if (bus.hold_request) begin
                    state_d = hold_state;
                end else if (pend) begin
                    state_d = first_state;
                    issue = 1'b1;
                end else begin
                    state_d = idle_state;
                end
            end
        end
    end

    // Any acknowledged later state completes the current cycle
    assign done = bus.state_end && ready && (state_q == second_state || state_q == pipe_no_request_state ||
                                             state_q == pipe_next_addr_state);

    always_ff @(posedge mclk) begin
        if (rst) begin
            state_q <= idle_state;
            bus.hold_ack <= 1'b0;
        end else begin
            state_q <= state_d;
            bus.hold_ack <= state_d == hold_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Current and early-issued cycle

    always_ff @(posedge mclk) begin
        if (rst) begin
            cur_q <= '0;
            nxt_q <= '0;
        end else begin
            if (issue && state_d == first_state) begin
                cur_q <= head;
            end else if (bus.state_end && state_q == pipe_next_addr_state && ready) begin
                cur_q <= nxt_q;
            end
            if (issue && state_d == pipe_next_addr_state) begin
                nxt_q <= head;
            end
        end
    end

    // Strobe is low for the whole of a first or next-address state
    always_ff @(posedge mclk) begin
        if (rst) begin
            bus.address_strobe_n <= 1'b1;
        end else if (bus.state_end) begin
            bus.address_strobe_n <= !(state_d == first_state || state_d == pipe_next_addr_state);
        end
    end

    // Address and definition change only on issue and stay put otherwise
    always_ff @(posedge mclk) begin
        if (rst) begin
            bus.word_address <= ADDR_RST;
            bus.upper_byte_enable_n <= 1'b1;
            bus.lower_byte_enable_n <= 1'b1;
            bus.write_not_read <= 1'b0;
            bus.data_not_control <= 1'b0;
            bus.memory_not_io <= 1'b0;
        end else if (issue) begin
            bus.word_address <= head.word_address;
            bus.upper_byte_enable_n <= head.upper_byte_enable_n;
            bus.lower_byte_enable_n <= head.lower_byte_enable_n;
            bus.write_not_read <= head.write_not_read;
            bus.data_not_control <= head.data_not_control;
            bus.memory_not_io <= head.memory_not_io;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Data pins: write data starts at phase two of a first state and, since it
    // only changes at a phase one end, holds through phase one after the ack

    always_ff @(posedge mclk) begin
        if (rst) begin
            bus.cpu_data_oe <= 1'b0;
            bus.cpu_data_out <= DATA_RST;
        end else if (p1_end) begin
            bus.cpu_data_oe <= cur_q.write_not_read && state_q != idle_state && state_q != hold_state;
            bus.cpu_data_out <= cur_q.wdata;
        end
    end

    // Read data is taken from the pins on the acknowledging state end
    always_ff @(posedge mclk) begin
        if (rst) begin
            rsp_valid <= 1'b0;
            rsp_write <= 1'b0;
            rsp_data <= DATA_RST;
        end else begin
            rsp_valid <= done;
            if (done) begin
                rsp_write <= cur_q.write_not_read;
                if (!cur_q.write_not_read) begin
                    rsp_data <= bus.data_bus;
                end
            end
        end
    end
endmodule

// File: common/pipe_bus_pkg.sv
package pipe_bus_pkg;

    // Bus widths: word address above bit zero, one 16-bit data word
    localparam int ADDR_W = 23;
    localparam int DATA_W = 16;

    // Depth of the request buffer in front of the sequencer
    localparam int BUF_DEPTH = 2;

    // Reset values of the driven bus fields
    localparam logic [ADDR_W-1:0] ADDR_RST = 23'h000000;
    localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;

    // Counts of the far end: wait states and completed states per cycle
    localparam int WAIT_W = 4;
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] CNT_MAX = 5'h1f;

    // Bus states of the sequencer
    typedef enum logic [2:0] {
        idle_state,
        hold_state,
        first_state,
        second_state,
        pipe_first_state,
        pipe_next_addr_state,
        pipe_no_request_state
    } bus_state_t;

    // One bus cycle as queued by the core and driven on the pins
    typedef struct packed {
        logic write_not_read;
        logic data_not_control;
        logic memory_not_io;
        logic upper_byte_enable_n;
        logic lower_byte_enable_n;
        logic [ADDR_W-1:0] word_address;
        logic [DATA_W-1:0] wdata;
    } bus_req_t;

endpackage

// File: common/pipe_bus_if.sv
interface pipe_bus_if (
    input wire logic mclk
);
    import pipe_bus_pkg::*;

    logic state_end;
    logic address_strobe_n;
    logic upper_byte_enable_n;
    logic lower_byte_enable_n;
    logic [ADDR_W-1:0] word_address;
    logic write_not_read;
    logic data_not_control;
    logic memory_not_io;
    logic hold_ack;
    logic [DATA_W-1:0] cpu_data_out;
    logic cpu_data_oe;
    logic [DATA_W-1:0] sys_data_out;
    logic sys_data_oe;
    logic cycle_done_n;
    logic next_address_request;
    logic hold_request;
    logic [DATA_W-1:0] data_bus;

    // Shared data wire; an undriven bus reads as all ones
    assign data_bus = cpu_data_oe ? cpu_data_out : (sys_data_oe ? sys_data_out : 16'hffff);

    modport cpu_end (
        output state_end, address_strobe_n, upper_byte_enable_n, lower_byte_enable_n, word_address,
        output write_not_read, data_not_control, memory_not_io, hold_ack, cpu_data_out, cpu_data_oe,
        input cycle_done_n, next_address_request, hold_request, data_bus
    );

    modport sys_end (
        input state_end, address_strobe_n, upper_byte_enable_n, lower_byte_enable_n, word_address,
        input write_not_read, data_not_control, memory_not_io, hold_ack, data_bus,
        output sys_data_out, sys_data_oe, cycle_done_n, next_address_request, hold_request
    );
endinterface

// File: hdl/system_bus_end.sv
module system_bus_end #(
    parameter int MEM_WORDS = 16
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [pipe_bus_pkg::WAIT_W-1:0] wait_states,
    input wire logic pipeline_enable,
    input wire logic hold_request_in,
    output logic done_valid,
    output logic done_write,
    output logic [pipe_bus_pkg::ADDR_W-1:0] done_addr,
    pipe_bus_if.sys_end bus
);
    import pipe_bus_pkg::*;

    localparam int IDX_W = $clog2(MEM_WORDS);

    if (MEM_WORDS < 2 || MEM_WORDS > 1024 || (MEM_WORDS & (MEM_WORDS - 1)) != 0) begin : g_bad_words
        $error("MEM_WORDS must be a power of two from 2 to 1024");
    end

    logic busy_q, busy_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic pend_q, pend_d;
    bus_req_t cur_q, cur_d, pend_cyc_q, pend_cyc_d, pins;
    logic ending, strobe;
    logic [DATA_W-1:0] mem_q [MEM_WORDS];
    logic [IDX_W-1:0] cur_idx, nxt_idx;

    ////////////////////////////////////////////////////////////////////////////
    // Cycle tracking, decided once per bus state

    assign strobe = !bus.address_strobe_n;
    assign pins = '{bus.write_not_read, bus.data_not_control, bus.memory_not_io, bus.upper_byte_enable_n,
                    bus.lower_byte_enable_n, bus.word_address, bus.data_bus};
    // The acknowledge we drive is the one the device samples at this state end
    assign ending = busy_q && !bus.cycle_done_n && cnt_q != '0;
    assign cur_idx = cur_q.word_address[IDX_W-1:0];
    assign nxt_idx = cur_d.word_address[IDX_W-1:0];

    // A strobe outside a cycle is a first state; inside one it is an early address
    always_comb begin
        busy_d = busy_q;
        cnt_d = cnt_q;
        pend_d = pend_q;
        cur_d = cur_q;
        pend_cyc_d = pend_cyc_q;
        if (bus.state_end) begin
            if (!busy_q) begin
                if (strobe) begin
                    busy_d = 1'b1;
                    cnt_d = 5'h01;
                    cur_d = pins;
                end
            end else if (ending) begin
                // Only an early address keeps the next cycle pipelined
                if (pend_q || strobe) begin
                    cnt_d = '0;
                    cur_d = strobe ? pins : pend_cyc_q;
                    pend_d = 1'b0;
                end else begin
                    busy_d = 1'b0;
                end
            end else begin
                if (cnt_q != CNT_MAX) begin
                    cnt_d = cnt_q + 5'h01;
                end
                if (strobe && cnt_q != '0) begin
                    pend_d = 1'b1;
                    pend_cyc_d = pins;
                end
            end
        end
    end

    // Registered tracking state
    always_ff @(posedge mclk) begin
        if (rst) begin
            busy_q <= 1'b0;
            cnt_q <= '0;
            pend_q <= 1'b0;
            cur_q <= '0;
            pend_cyc_q <= '0;
        end else begin
            busy_q <= busy_d;
            cnt_q <= cnt_d;
            pend_q <= pend_d;
            cur_q <= cur_d;
            pend_cyc_q <= pend_cyc_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Acknowledge and requests; never acknowledge in a cycle's first state

    always_ff @(posedge mclk) begin
        if (rst) begin
            bus.cycle_done_n <= 1'b1;
            bus.next_address_request <= 1'b0;
            bus.hold_request <= 1'b0;
        end else begin
            if (bus.state_end) begin
                bus.cycle_done_n <= !(busy_d && cnt_d >= ({1'b0, wait_states} + 5'h01));
            end
            bus.next_address_request <= pipeline_enable;
            bus.hold_request <= hold_request_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data is driven in the later states of a read only, so the
    // device's write data of the following cycle never meets it

    always_ff @(posedge mclk) begin
        if (rst) begin
            bus.sys_data_oe <= 1'b0;
            bus.sys_data_out <= DATA_RST;
        end else if (bus.state_end) begin
            bus.sys_data_oe <= busy_d && !cur_d.write_not_read && cnt_d != '0;
            bus.sys_data_out <= mem_q[nxt_idx];
        end
    end

    // Write capture with byte enables, and one completion pulse per cycle
    always_ff @(posedge mclk) begin
        if (rst) begin
            done_valid <= 1'b0;
            done_write <= 1'b0;
            done_addr <= ADDR_RST;
        end else begin
            done_valid <= bus.state_end && ending;
            if (bus.state_end && ending) begin
                done_write <= cur_q.write_not_read;
                done_addr <= cur_q.word_address;
            end
        end
    end

    // Memory contents carry no reset
    always_ff @(posedge mclk) begin
        if (bus.state_end && ending && cur_q.write_not_read) begin
            if (!cur_q.lower_byte_enable_n) begin
                mem_q[cur_idx][7:0] <= bus.data_bus[7:0];
            end
            if (!cur_q.upper_byte_enable_n) begin
                mem_q[cur_idx][15:8] <= bus.data_bus[15:8];
            end
        end
    end
endmodule

// File: sim/pipelined_address_bus_sequencer_chk.sv
module pipelined_address_bus_sequencer_chk (
    input wire logic mclk,
    input wire logic rst,
    input wire logic state_end,
    input wire logic address_strobe_n,
    input wire logic upper_byte_enable_n,
    input wire logic lower_byte_enable_n,
    input wire logic [pipe_bus_pkg::ADDR_W-1:0] word_address,
    input wire logic write_not_read,
    input wire logic data_not_control,
    input wire logic memory_not_io,
    input wire logic hold_ack,
    input wire logic cpu_data_oe,
    input wire logic cycle_done_n,
    input wire logic hold_request
);
    timeunit 1ns;
    timeprecision 1ps;
    import pipe_bus_pkg::*;

    // One clock domain, so clocking and disable are stated once
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////
    // Reset must be seen, so this one is never disabled
    AST_RESET_QUIET: assert property (disable iff (1'b0) rst |=>
        address_strobe_n && !cpu_data_oe && !hold_ack)
        else $error("bus not quiet after reset");
    AST_STATE_SPAN: assert property (!state_end |=> state_end)
        else $error("bus state longer than two clocks");
    AST_STROBE_HOLDS: assert property (!state_end |=> $stable(address_strobe_n))
        else $error("strobe moved inside a bus state");
    // Address and definition only move when a new cycle is issued
    AST_ISSUE_WITH_STROBE: assert property ($changed({upper_byte_enable_n, lower_byte_enable_n, word_address,
        write_not_read, data_not_control, memory_not_io}) |-> !address_strobe_n)
        else $error("address changed without strobe");
    AST_HOLD_CAUSE: assert property ($rose(hold_ack) |-> $past(hold_request) && $past(state_end))
        else $error("hold ack without request at state end");
    AST_HOLD_NO_ISSUE: assert property (hold_ack |-> address_strobe_n)
        else $error("strobe during hold");
    // The pins may already show the next cycle's early address, so look one edge back
    AST_WDATA_START: assert property ($rose(cpu_data_oe) |-> state_end && $past(write_not_read))
        else $error("write data not started in phase two of a write");
    // Hold time: the drive ends one phase after the acknowledging edge
    AST_WDATA_HOLD: assert property ($fell(cpu_data_oe) |-> $past(state_end, 2) && !$past(cycle_done_n, 2))
        else $error("write data released at the wrong time");
endmodule

// File: sim/pipelined_address_bus_sequencer_tb.sv
module pipelined_address_bus_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pipe_bus_pkg::*;

    localparam int LIMIT = 20000;
    logic mclk, rst, doubled, req_valid, req_ready, rsp_valid, rsp_write;
    logic pipeline_enable, hold_request_in, done_valid, done_write, prev_strobe_n;
    logic [DATA_W-1:0] rsp_data;
    logic [WAIT_W-1:0] wait_states;
    logic [ADDR_W-1:0] done_addr;
    logic [ADDR_W-1:0] wa [16];
    logic [DATA_W-1:0] mem_model [16];
    bus_req_t req_cycle;
    bus_req_t q_rsp[$], q_done[$], q_issue[$];
    int fail_count, compares, cycles, issues, dones, max_out, first_out, gmin, gmax, last_fall, m;

    pipe_bus_if bus_if (.mclk(mclk));
    bus_sequencer bus_sequencer_inst (.mclk(mclk), .rst(rst), .clock_doubled(doubled), .req_valid(req_valid),
        .req_cycle(req_cycle), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_write(rsp_write),
        .rsp_data(rsp_data), .bus(bus_if.cpu_end));
    system_bus_end #(.MEM_WORDS(16)) system_bus_end_inst (.mclk(mclk), .rst(rst), .wait_states(wait_states),
        .pipeline_enable(pipeline_enable), .hold_request_in(hold_request_in), .done_valid(done_valid),
        .done_write(done_write), .done_addr(done_addr), .bus(bus_if.sys_end));
    pipelined_address_bus_sequencer_chk pipelined_address_bus_sequencer_chk_inst (.mclk(mclk), .rst(rst),
        .state_end(bus_if.state_end), .address_strobe_n(bus_if.address_strobe_n),
        .upper_byte_enable_n(bus_if.upper_byte_enable_n), .lower_byte_enable_n(bus_if.lower_byte_enable_n),
        .word_address(bus_if.word_address), .write_not_read(bus_if.write_not_read),
        .data_not_control(bus_if.data_not_control), .memory_not_io(bus_if.memory_not_io),
        .hold_ack(bus_if.hold_ack), .cpu_data_oe(bus_if.cpu_data_oe), .cycle_done_n(bus_if.cycle_done_n),
        .hold_request(bus_if.hold_request));

    // 50 MHz clock
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    ////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Hang guard: the whole run needs about a thousand clocks
    always @(posedge mclk) begin
        cycles++;
        if (cycles == LIMIT) begin
            check("timeout", 32'h1, 32'h0);
            conclude();
        end
    end

    // Results monitor: pops the oldest note whenever a result shows
    always @(posedge mclk) begin
        bus_req_t e;
        if (rst) begin
            prev_strobe_n = 1'b1;
        end else begin
            if (rsp_valid === 1'b1) begin
                e = q_rsp.pop_front();
                check("rsp_write", rsp_write, e.write_not_read);
                if (!e.write_not_read) check("rsp_data", rsp_data, e.wdata);
            end
            if (done_valid === 1'b1) begin
                e = q_done.pop_front();
                dones++;
                check("done_addr", 32'({done_write, done_addr}), 32'({e.write_not_read, e.word_address}));
            end
            // A falling strobe is one issue; repeated next-address states keep it low
            if (prev_strobe_n === 1'b1 && bus_if.address_strobe_n === 1'b0) begin
                e = q_issue.pop_front();
                issues++;
                check("issue", 32'({bus_if.upper_byte_enable_n, bus_if.lower_byte_enable_n, bus_if.word_address,
                    bus_if.write_not_read, bus_if.data_not_control, bus_if.memory_not_io}),
                    32'({e.upper_byte_enable_n, e.lower_byte_enable_n, e.word_address, e.write_not_read,
                    e.data_not_control, e.memory_not_io}));
                if (last_fall >= 0 && cycles - last_fall < gmin) gmin = cycles - last_fall;
                if (last_fall >= 0 && cycles - last_fall > gmax) gmax = cycles - last_fall;
                last_fall = cycles;
                if (first_out < 0) first_out = issues - dones;
            end
            prev_strobe_n = bus_if.address_strobe_n;
            if (issues - dones > max_out) max_out = issues - dones;
        end
    end

    ////////////////////////////////////////////////////////////
    task automatic reset_dut();
        rst <= 1'b1;
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        repeat (2) @(posedge mclk);
        check("strobe_idle", 32'({bus_if.address_strobe_n, bus_if.cpu_data_oe, bus_if.hold_ack}), 32'h4);
    endtask

    // Holds the offer until the edge that takes it, then notes the outcome
    task automatic send(input bus_req_t r);
        req_valid <= 1'b1;
        req_cycle <= r;
        @(posedge mclk);
        while (req_ready !== 1'b1) @(posedge mclk);
        if (r.write_not_read) mem_model[r.word_address[3:0]] = r.wdata;
        else r.wdata = mem_model[r.word_address[3:0]];
        q_rsp.push_back(r);
        q_done.push_back(r);
        q_issue.push_back(r);
    endtask

    task automatic drain();
        for (int k = 0; k < 600 && q_rsp.size() + q_done.size() + q_issue.size() > 0; k++) @(posedge mclk);
        check("left_over", q_rsp.size() + q_done.size() + q_issue.size(), 0);
    endtask

    // Back-to-back stream: n writes, then n reads of the same words
    task automatic run(input logic dbl, input int w, input logic pe, input int n, input string name);
        bus_req_t r;
        doubled <= dbl;
        wait_states <= WAIT_W'(w);
        pipeline_enable <= pe;
        reset_dut();
        gmin = 1000;
        gmax = 0;
        last_fall = -1;
        max_out = 0;
        first_out = -1;
        for (int k = 0; k < 2 * n; k++) begin
            if (k < n) wa[k] = {(ADDR_W-4)'($urandom), 4'(k)};
            r = bus_req_t'({$urandom, $urandom});
            r.write_not_read = (k < n);
            r.upper_byte_enable_n = 1'b0;
            r.lower_byte_enable_n = 1'b0;
            r.word_address = wa[k % n];
            send(r);
        end
        req_valid <= 1'b0;
        drain();
        if (!pe) check("gap_min", gmin, (2 + w) * (dbl ? 1 : 2));
        if (!pe) check("gap_max", gmax, (2 + w) * (dbl ? 1 : 2));
        check("first_overlap", first_out, 1);
        check("max_overlap", max_out, (pe && w > 0) ? 2 : 1);
        $display("test %s mode %0d waits %0d done", name, dbl, w);
    endtask

    // Hold parks the bus; the first queued cycle restarts without pipelining
    task automatic hold_test();
        bus_req_t r;
        int seen;
        hold_request_in <= 1'b1;
        for (int k = 0; k < 20 && bus_if.hold_ack !== 1'b1; k++) @(posedge mclk);
        check("hold_ack", bus_if.hold_ack, 1);
        seen = issues;
        first_out = -1;
        max_out = 0;
        for (int k = 0; k < 2; k++) begin
            r = '0;
            r.word_address = wa[k];
            send(r);
        end
        req_valid <= 1'b0;
        repeat (10) @(posedge mclk);
        check("issues_in_hold", issues, seen);
        hold_request_in <= 1'b0;
        drain();
        check("first_after_hold", first_out, 1);
        $display("test hold done");
    endtask

    ////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1;
        doubled = 1'b0;
        req_valid = 1'b0;
        req_cycle = '0;
        wait_states = '0;
        pipeline_enable = 1'b0;
        hold_request_in = 1'b0;
        prev_strobe_n = 1'b1;
        {fail_count, compares, cycles, issues, dones} = '0;
        void'($urandom(9));
        @(posedge mclk);
        for (m = 0; m < 2; m++) begin
            run(1'(m), 0, 1'b0, 8, "plain_fast");
            run(1'(m), 2, 1'b0, 6, "plain_waited");
            run(1'(m), 1, 1'b1, 8, "pipe_one_wait");
            run(1'(m), 0, 1'b1, 6, "pipe_no_wait");
            run(1'(m), $urandom_range(3, 1), 1'b1, 8, "pipe_random");
        end
        hold_test();
        conclude();
    end
endmodule
